// *** rtl/sar_ctrl_pkg.sv ***
// Purpose: Shared constants and types for the SAR converter serial control
// Assumes: Core clock of 25 MHz; serial clock comes from the host
// Notes:   Control word layout is expressed as a packed struct, MSB first
package sar_ctrl_pkg;

    localparam int DATA_W     = 12;
    localparam int ID_W       = 4;
    localparam int FRAME_BITS = 16;
    localparam int CNT_W      = 5;
    localparam int IDX_W      = 4;
    localparam int HOLD_EDGE  = 14;
    localparam int N_AIN      = 8;
    localparam int N_SRC      = 9;
    localparam int AVG_SHIFT  = 3;
    localparam int ACC_W      = DATA_W + AVG_SHIFT;

    localparam logic [ID_W-1:0] TEMP_ID  = 4'h8;
    localparam logic [ID_W-1:0] FIRST_ID = 4'h0;

    // Converter timing
    localparam int CLK_HZ        = 25_000_000;
    localparam int TEMP_CONV_US  = 100;
    localparam int TEMP_CONV_CYC = (CLK_HZ / 1_000_000) * TEMP_CONV_US;
    localparam int TCNT_W        = 12;

    typedef struct packed {
        logic             wr;
        logic             rpt;
        logic [N_AIN-1:0] ain;      // MSB is input 0
        logic             tsense;
        logic [1:0]       spare;
        logic             external_reference_select;
        logic             avg;
        logic             standby;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = '0;

    typedef struct packed {
        logic [ID_W-1:0]   id;
        logic [DATA_W-1:0] data;
    } frame_t;

    localparam frame_t FRAME_IDLE = '1;

    typedef struct packed {
        logic            hit;
        logic [ID_W-1:0] ch;
    } pick_t;

    typedef enum logic [1:0] {
        T_OFF  = 2'b00,
        T_BUSY = 2'b01,
        T_DONE = 2'b10
    } temp_state_t;

endpackage : sar_ctrl_pkg

// *** rtl/sar_serial_link.sv ***
// Purpose: Serial-clock side of the frame: shifts the result out, the control word in
// Assumes: Chip select low frames exactly one 16-clock transfer
// Notes:   Chip select high asynchronously re-arms the frame
`timescale 1ns/1ps
module sar_serial_link
    import sar_ctrl_pkg::*;
(
    input  wire logic                  serial_clk_i,
    input  wire logic                  rst_b_i,
    input  wire logic                  chip_select_b_i,
    input  wire logic                  serial_data_in_i,
    input  wire frame_t                tx_frame_i,
    output logic                       serial_output_line_o,
    output logic                       serial_output_oe_o,
    output logic                       sample_hold_o,
    output logic [FRAME_BITS-1:0]      rx_word_o,
    output logic                       frame_tgl_o
);

    typedef struct packed {
        logic [CNT_W-1:0]      cnt;
        logic [FRAME_BITS-2:0] shift;
        logic [FRAME_BITS-1:0] rx;
        logic                  tgl;
    } link_t;

    link_t            s_r;
    link_t            s_nxt;
    logic             idle_r;
    logic [CNT_W-1:0] cnt_eff;
    logic             active;
    logic [IDX_W-1:0] bit_idx;

    // Frame start needs no serial edge, so chip select itself re-arms the count
    always_ff @(negedge serial_clk_i or posedge chip_select_b_i or negedge rst_b_i) begin
        if (!rst_b_i || chip_select_b_i) begin
            idle_r <= 1'b1;
        end else begin
            idle_r <= 1'b0;
        end
    end

    assign cnt_eff = idle_r ? '0 : s_r.cnt;
    assign active  = !chip_select_b_i && (cnt_eff < CNT_W'(FRAME_BITS));
    assign bit_idx = IDX_W'(FRAME_BITS - 1) - cnt_eff[IDX_W-1:0];

    always_comb begin
        s_nxt = s_r;
        if (active) begin
            s_nxt.cnt   = cnt_eff + CNT_W'(1);
            s_nxt.shift = {s_r.shift[FRAME_BITS-3:0], serial_data_in_i};
            if (cnt_eff == CNT_W'(FRAME_BITS - 1)) begin
                s_nxt.rx  = {s_r.shift, serial_data_in_i};
                s_nxt.tgl = !s_r.tgl;
            end
        end
    end

    always_ff @(negedge serial_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // First bit appears at chip select fall, the rest on each falling edge
    assign serial_output_line_o = active ? tx_frame_i[bit_idx] : 1'b0;
    assign serial_output_oe_o   = active;
    assign sample_hold_o        = !idle_r && (s_r.cnt >= CNT_W'(HOLD_EDGE));
    assign rx_word_o            = s_r.rx;
    assign frame_tgl_o          = s_r.tgl;

endmodule : sar_serial_link

// *** rtl/sar_adc_serial_control.sv ***
// Purpose: Digital control of an eight-input SAR converter with temperature sensor
// Assumes: Analog core delivers the frame's code on adc_result_i at frame end
// Notes:   Frames complete on the serial clock; the core follows a toggle crossing
//
// Functional notes
// - No channel after reset; frames read all ones
// - Selected channels convert in order, repeat optional
// - Sensor select bit adds temperature sensor source
// - Busy pin high from select until conversion done
// - Averaging off gives raw sensor results
// - Averaging bit kept set; clearing resets filter
// - Average is seven eighths old plus one eighth
// - Filtered value readable in following frame
// - First averaged output equals raw result
// - Temperature is 12-bit two's complement, quarter degree
// - Reference select: zero internal, one external
// - Analog results straight binary, temperature two's complement
// - Serial clock runs conversion and data shifting
// - Chip select fall drives output; input sampled on serial falls
// - Mux switches, hold entered by 14th edge
// - Output floats at 16th edge or deselect
// - Short frame aborts, control word unchanged
// - Frame is channel id then 12-bit result
// - First bit at select fall, rest on falls
// - Input captured on 16 falls, needs write bit
// - Control word bit layout fixed as documented
// - Control word all zeros after reset
`timescale 1ns/1ps
module sar_adc_serial_control
    import sar_ctrl_pkg::*;
#(
    parameter int TEMP_CYCLES = TEMP_CONV_CYC
)(
    input  wire logic                clk_i,
    input  wire logic                rst_b_i,
    input  wire logic                clk_en_i,
    input  wire logic                serial_clk_i,
    input  wire logic                chip_select_b_i,
    input  wire logic                serial_data_in_i,
    input  wire logic [DATA_W-1:0]   adc_result_i,
    input  wire logic [DATA_W-1:0]   temp_code_i,
    output logic                     serial_output_line_o,
    output logic                     serial_output_oe_o,
    output logic                     sample_hold_o,
    output logic [ID_W-1:0]          mux_channel_o,
    output logic                     external_reference_select_o,
    output logic                     temp_conv_busy_pin_o,
    output logic                     standby_o
);

    typedef struct packed {
        ctrl_t               ctrl;
        logic [2:0]          tsync;
        frame_t              tx;
        logic                run;
        logic [ID_W-1:0]     cur_ch;
        temp_state_t         tstate;
        logic                busy;
        logic [TCNT_W-1:0]   tcnt;
        logic [DATA_W-1:0]   traw;
        logic [ACC_W-1:0]    acc;
        logic                avg_valid;
    } core_t;

    localparam core_t CORE_RESET = '{
        ctrl:      CTRL_RESET,
        tsync:     '0,
        tx:        FRAME_IDLE,
        run:       1'b0,
        cur_ch:    FIRST_ID,
        tstate:    T_OFF,
        busy:      1'b0,
        tcnt:      '0,
        traw:      '0,
        acc:       '0,
        avg_valid: 1'b0
    };

    core_t                 r;
    core_t                 n;
    logic [FRAME_BITS-1:0] rx_word;
    logic                  frame_tgl;
    ctrl_t                 rx_ctrl;
    logic                  frame_evt;
    logic [N_SRC-1:0]      mask_cur;
    logic [N_SRC-1:0]      mask_new;
    logic [DATA_W-1:0]     temp_val;
    logic [ACC_W-1:0]      raw_ext;
    pick_t                 nxt_after;
    pick_t                 nxt_first;
    pick_t                 new_first;

    sar_serial_link u_link (
        .serial_clk_i         (serial_clk_i),
        .rst_b_i              (rst_b_i),
        .chip_select_b_i      (chip_select_b_i),
        .serial_data_in_i     (serial_data_in_i),
        .tx_frame_i           (r.tx),
        .serial_output_line_o (serial_output_line_o),
        .serial_output_oe_o   (serial_output_oe_o),
        .sample_hold_o        (sample_hold_o),
        .rx_word_o            (rx_word),
        .frame_tgl_o          (frame_tgl)
    );

    // Source mask: inputs 0..7 ascending, sensor last
    genvar gi;
    generate
        for (gi = 0; gi < N_AIN; gi++) begin : g_mask
            assign mask_cur[gi] = r.ctrl.ain[N_AIN-1-gi];
            assign mask_new[gi] = rx_ctrl.ain[N_AIN-1-gi];
        end
    endgenerate
    assign mask_cur[N_SRC-1] = r.ctrl.tsense;
    assign mask_new[N_SRC-1] = rx_ctrl.tsense;

    // Lowest selected source above a given one, or from the start
    function automatic pick_t pick_src(
        input logic [N_SRC-1:0] mask,
        input logic [ID_W-1:0]  after,
        input logic             from_start
    );
        pick_t res;
        res = '0;
        for (int i = 0; i < N_SRC; i++) begin
            if (!res.hit && mask[i] && (from_start || (ID_W'(i) > after))) begin
                res.hit = 1'b1;
                res.ch  = ID_W'(i);
            end
        end
        return res;
    endfunction : pick_src

    assign rx_ctrl   = ctrl_t'(rx_word);
    assign frame_evt = r.tsync[1] ^ r.tsync[2];
    assign nxt_after = pick_src(mask_cur, r.cur_ch, 1'b0);
    assign nxt_first = pick_src(mask_cur, FIRST_ID, 1'b1);
    assign new_first = pick_src(mask_new, FIRST_ID, 1'b1);
    assign raw_ext   = {{AVG_SHIFT{temp_code_i[DATA_W-1]}}, temp_code_i};
    // Sensor codes stay two's complement; the filtered value once averaging is valid, else the raw code
    assign temp_val  = r.avg_valid ? r.acc[ACC_W-1:AVG_SHIFT] : r.traw;

    always_comb begin
        n       = r;
        n.tsync = {r.tsync[1:0], frame_tgl};

        // Sensor conversion runs on the core clock, bounded by its worst case
        if (r.tstate == T_BUSY) begin
            if (r.tcnt == '0) begin
                n.tstate = T_DONE;
                n.busy   = 1'b0;
                n.traw   = temp_code_i;
                if (r.ctrl.avg && r.ctrl.tsense) begin
                    if (!r.avg_valid) begin
                        n.acc       = {temp_code_i, {AVG_SHIFT{1'b0}}};
                        n.avg_valid = 1'b1;
                    end else begin
                        // Keeps three fraction bits so small steps are not lost
                        n.acc = r.acc - ACC_W'($signed(r.acc) >>> AVG_SHIFT)
                              + raw_ext;
                    end
                end
            end else begin
                n.tcnt = r.tcnt - TCNT_W'(1);
            end
        end

        if (frame_evt) begin
            // Result of this frame's conversion goes out in the next frame
            if (r.run) begin
                n.tx.id   = r.cur_ch;
                n.tx.data = (r.cur_ch == TEMP_ID) ? temp_val : adc_result_i;
            end else begin
                n.tx = FRAME_IDLE;
            end

            if (rx_ctrl.wr) begin
                n.ctrl   = rx_ctrl;
                n.run    = new_first.hit;
                n.cur_ch = new_first.hit ? new_first.ch : FIRST_ID;
                if (!rx_ctrl.avg) begin
                    n.acc       = '0;
                    n.avg_valid = 1'b0;
                end
                if (!rx_ctrl.tsense) begin
                    n.tstate = T_OFF;
                    n.busy   = 1'b0;
                end else if (r.tstate != T_BUSY) begin
                    n.tstate = T_BUSY;
                    n.busy   = 1'b1;
                    n.tcnt   = TCNT_W'(TEMP_CYCLES - 1);
                end
            end else if (r.run) begin
                if (r.cur_ch == TEMP_ID && r.ctrl.tsense && r.tstate != T_BUSY) begin
                    n.tstate = T_BUSY;
                    n.busy   = 1'b1;
                    n.tcnt   = TCNT_W'(TEMP_CYCLES - 1);
                end
                if (nxt_after.hit) begin
                    n.cur_ch = nxt_after.ch;
                end else if (r.ctrl.rpt && nxt_first.hit) begin
                    n.cur_ch = nxt_first.ch;
                end else begin
                    n.run = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r <= CORE_RESET;
        end else if (clk_en_i) begin
            r <= n;
        end
    end

    // Mux is set between frames, well ahead of the hold edge
    assign mux_channel_o               = r.cur_ch;
    assign external_reference_select_o = r.ctrl.external_reference_select;
    assign temp_conv_busy_pin_o        = r.busy;
    assign standby_o                   = r.ctrl.standby;

endmodule : sar_adc_serial_control

// *** test/sar_adc_serial_control_properties.sv ***
// Purpose: Pin timing checks for the converter serial control
// Assumes: Serial clock idles high between frames
// Notes:   Fall counter mirrors the link position from outside
`timescale 1ns/1ps
module sar_adc_serial_control_checker
    import sar_ctrl_pkg::*;
#(
    parameter int TEMP_CYCLES = 4
)(
    input wire logic            clk_i,
    input wire logic            rst_b_i,
    input wire logic            serial_clk_i,
    input wire logic            chip_select_b_i,
    input wire logic            serial_output_oe_o,
    input wire logic            sample_hold_o,
    input wire logic [ID_W-1:0] mux_channel_o,
    input wire logic            external_reference_select_o,
    input wire logic            temp_conv_busy_pin_o,
    input wire logic            standby_o
);
    logic [4:0]  falls_r;
    logic        full_r;
    logic [11:0] busy_cnt_r;

    // Deselect clears the count, so a short frame never reaches 16
    always_ff @(negedge serial_clk_i or posedge chip_select_b_i or negedge rst_b_i) begin
        if (!rst_b_i || chip_select_b_i) begin
            falls_r <= 5'h00;
        end else if (falls_r != 5'h10) begin
            falls_r <= falls_r + 5'h01;
        end
    end

    // Held through the gap so the core may react after deselect
    always_ff @(negedge serial_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            full_r <= 1'b0;
        end else begin
            full_r <= (falls_r == 5'h0f);
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_cnt_r <= 12'h000;
        end else begin
            busy_cnt_r <= temp_conv_busy_pin_o ? busy_cnt_r + 12'h001 : 12'h000;
        end
    end

    AST_OE_SELECT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !chip_select_b_i && falls_r < 5'h10 |-> serial_output_oe_o) else $error("output not driven in frame");
    AST_OE_END: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !chip_select_b_i && falls_r == 5'h10 |-> !serial_output_oe_o) else $error("output driven after 16 falls");
    AST_OE_DESELECT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        chip_select_b_i |-> !serial_output_oe_o) else $error("output driven while deselected");
    AST_HOLD_SET: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !chip_select_b_i && falls_r >= 5'h0e |-> sample_hold_o) else $error("hold missing after 14 falls");
    AST_RESET_VALS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $rose(rst_b_i) |-> !external_reference_select_o && !standby_o && !temp_conv_busy_pin_o
        && mux_channel_o == 4'h0) else $error("control pins not cleared by reset");
    AST_CTRL_AFTER_FRAME: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $changed(external_reference_select_o) || $changed(standby_o) || $changed(mux_channel_o)
        |-> full_r) else $error("control changed without a full frame");
    AST_BUSY_START: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $rose(temp_conv_busy_pin_o) |-> full_r) else $error("busy rose without a full frame");
    AST_BUSY_MAX: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        temp_conv_busy_pin_o |-> busy_cnt_r < TEMP_CYCLES + 2) else $error("busy held too long");
endmodule : sar_adc_serial_control_checker

bind sar_adc_serial_control sar_adc_serial_control_checker #(.TEMP_CYCLES(TEMP_CYCLES)) u_checker (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .serial_clk_i(serial_clk_i), .chip_select_b_i(chip_select_b_i),
    .serial_output_oe_o(serial_output_oe_o), .sample_hold_o(sample_hold_o), .mux_channel_o(mux_channel_o),
    .external_reference_select_o(external_reference_select_o),
    .temp_conv_busy_pin_o(temp_conv_busy_pin_o), .standby_o(standby_o)
);

// *** test/sar_host_model.sv ***
// Purpose: Host serial master driving 16-clock frames
// Assumes: 6 ns serial period, clock stands high outside frames
// Notes:   Bits read while the output floats come back unknown
`timescale 1ns/1ps
module sar_host_model (
    output logic     serial_clk_o,
    output logic     chip_select_b_o,
    output logic     serial_data_o,
    input wire logic serial_line_i,
    input wire logic line_oe_i
);
    // Same frame as seen by a host that samples on rising edges
    logic [14:0] rd_rise;

    initial begin
        serial_clk_o = 1'b1;
        chip_select_b_o = 1'b1;
        serial_data_o = 1'b0;
    end

    task automatic frame(input logic [15:0] w, input int n, output logic [15:0] rd);
        rd = '1;
        rd_rise = '1;
        chip_select_b_o = 1'b0;
        serial_data_o = w[15];
        for (int k = 1; k <= n; k++) begin
            #3 rd[16-k] = line_oe_i ? serial_line_i : 1'bx;
            serial_clk_o = 1'b0;
            #3 serial_clk_o = 1'b1;
            if (k < 16) rd_rise[15-k] = line_oe_i ? serial_line_i : 1'bx;
            serial_data_o = (k < 16) ? w[15-k] : ~w[0];
        end
        #50 chip_select_b_o = 1'b1;
        serial_data_o = ~serial_data_o;
        #400;
    endtask : frame
endmodule : sar_host_model

// *** test/sar_adc_serial_control_tb.sv ***
// Purpose: Frame-level tests of the converter serial control
// Assumes: Host model shifts frames at a 6 ns serial period
// Notes:   Frame N reports the code sampled when frame N-1 ended
`timescale 1ns/1ps
module sar_adc_serial_control_tb;
    import sar_ctrl_pkg::*;
    logic              clk_i = 1'b0;
    logic              rst_b_i = 1'b0;
    logic [DATA_W-1:0] adc_result_i = '0;
    logic [DATA_W-1:0] temp_code_i = '0;
    logic              sclk, cs_b, din, dout, oe, hold, ext, busy, stby, seen;
    logic [ID_W-1:0]   mux;
    logic [15:0]       rd;
    int                err_count = 0;
    int                compares = 0;

    sar_adc_serial_control #(.TEMP_CYCLES(4)) u_sar_adc_serial_control (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .clk_en_i(1'b1), .serial_clk_i(sclk),
        .chip_select_b_i(cs_b), .serial_data_in_i(din), .adc_result_i(adc_result_i),
        .temp_code_i(temp_code_i), .serial_output_line_o(dout), .serial_output_oe_o(oe),
        .sample_hold_o(hold), .mux_channel_o(mux), .external_reference_select_o(ext),
        .temp_conv_busy_pin_o(busy), .standby_o(stby)
    );
    sar_host_model u_sar_host_model (
        .serial_clk_o(sclk), .chip_select_b_o(cs_b), .serial_data_o(din),
        .serial_line_i(dout), .line_oe_i(oe)
    );

    always #20 clk_i = ~clk_i;

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Runs a frame, then sets the code the next frame converts
    task automatic xfer(input logic [15:0] w, input logic [11:0] code, input logic [15:0] exp, input bit ck);
        u_sar_host_model.frame(w, 16, rd);
        if (ck) chk("frame", exp, rd);
        if (ck) chk("rise", {1'b0, exp[14:0]}, {1'b0, u_sar_host_model.rd_rise});
        @(negedge clk_i) adc_result_i = code;
    endtask : xfer

    task tally_and_finish;
        if (err_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20) @(negedge clk_i);
        rst_b_i = 1'b1;
        repeat (3) @(negedge clk_i);
        chk("pins", 16'h0000, {7'h00, ext, busy, stby, mux, oe, hold});
        xfer(16'h7fff, 12'h000, 16'hffff, 1'b1);
        xfer(16'h0000, 12'h000, 16'hffff, 1'b1);
        chk("pins", 16'h0000, {7'h00, ext, busy, stby, mux, oe, hold});
        xfer(16'hd405, 12'h123, 16'hffff, 1'b1);
        chk("pins", 16'h0144, {7'h00, ext, busy, stby, mux, oe, hold});
        xfer(16'h0000, 12'h456, 16'h0000, 1'b0);
        xfer(16'h0000, 12'h789, 16'h1123, 1'b1);
        xfer(16'h0000, 12'habc, 16'h3456, 1'b1);
        xfer(16'h0000, 12'h000, 16'h1789, 1'b1);
        u_sar_host_model.frame(16'h8000, 10, rd);
        chk("pins", 16'h0144, {7'h00, ext, busy, stby, mux, oe, hold});
        xfer(16'h8800, 12'h0ff, 16'h3abc, 1'b1);
        xfer(16'h0000, 12'h111, 16'h0000, 1'b0);
        xfer(16'h0000, 12'h000, 16'h20ff, 1'b1);
        xfer(16'h0000, 12'h000, 16'hffff, 1'b1);
        @(negedge clk_i) temp_code_i = 12'h064;
        fork
            xfer(16'h8020, 12'h000, 16'h0000, 1'b0);
            begin
                seen = 1'b0;
                repeat (30) @(posedge clk_i) seen |= busy;
            end
        join
        chk("busy", 16'h0001, {15'h0000, seen});
        xfer(16'h0000, 12'h000, 16'h0000, 1'b0);
        xfer(16'h0000, 12'h000, 16'h8064, 1'b1);
        // Sensor code set before a frame is the one its conversion captures
        @(negedge clk_i) temp_code_i = 12'h080;
        xfer(16'hc022, 12'h000, 16'h0000, 1'b0);
        @(negedge clk_i) temp_code_i = 12'h000;
        xfer(16'h0000, 12'h000, 16'h0000, 1'b0);
        xfer(16'h0000, 12'h000, 16'h8080, 1'b1);
        xfer(16'h0000, 12'h000, 16'h8070, 1'b1);
        xfer(16'h0000, 12'h000, 16'h8062, 1'b1);
        @(negedge clk_i) temp_code_i = 12'hfff;
        xfer(16'hc020, 12'h000, 16'h0000, 1'b0);
        xfer(16'h0000, 12'h000, 16'h0000, 1'b0);
        xfer(16'h0000, 12'h000, 16'h8fff, 1'b1);
        tally_and_finish();
    end

    // Limit of 200 us, far above the 23 frames of about half a microsecond each
    initial begin
        #200_000;
        err_count++;
        tally_and_finish();
    end
endmodule : sar_adc_serial_control_tb
